// ### design/hpsr_fifo.sv
// Purpose: host output queue, valid/ready on both sides
// Assumes: DEPTH is a power of two
// Notes:   flush empties it in one cycle
`timescale 1ns/100ps
`default_nettype none
module hpsr_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             nrst_i,
  input  wire logic             flush_i,
  // fill side
  input  wire logic             in_valid_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  in_ready_o,
  // drain side
  output logic                  out_valid_o,
  output logic      [WIDTH-1:0] out_data_o,
  input  wire logic             out_ready_i
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr_reg;
  logic [AW:0]      rd_ptr_reg;
  logic             push;
  logic             pop;

  assign in_ready_o  = (wr_ptr_reg - rd_ptr_reg) != (AW+1)'(DEPTH);
  assign out_valid_o = wr_ptr_reg != rd_ptr_reg;
  assign out_data_o  = mem[rd_ptr_reg[AW-1:0]];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr_reg[AW-1:0]] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else if (flush_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      if (push) wr_ptr_reg <= wr_ptr_reg + 1'b1;
      if (pop)  rd_ptr_reg <= rd_ptr_reg + 1'b1;
    end
  end
endmodule : hpsr_fifo
`default_nettype wire

// ### design/hpsr_pkg.sv
// Purpose: shared constants for the host port stream router
// Assumes: ports numbered 1..13, port 0 is the mainframe itself
// Notes:   one flat package, referenced by scoped names only
package hpsr_pkg;

  localparam int          PORT_W      = 4;
  localparam int          NPORT       = 16;
  localparam int          ESC_MAX     = 8;
  localparam int          BAUD_W      = 18;
  localparam int          FIFO_WORDS  = 8;
  localparam int          PEND_WORDS  = 4;

  localparam logic [BAUD_W-1:0] BAUD_DEFAULT = 18'h0_2580;
  localparam logic [6:0]  VERBOSITY_LEVEL_DEBUG  = 7'h7F;
  localparam logic [7:0]  CHAR_LF     = 8'h0A;
  // packet marker value is arbitrary
  localparam logic [7:0]  PKT_MARK    = 8'h23;
  localparam logic [7:0]  PKT_COUNT   = 8'h01;
  localparam logic [NPORT-1:0] MODULE_PORT_MASK = 16'h03FE;

  // break duration on module ports
  localparam int          CLK_KHZ       = 32'h0000_4E20;
  localparam int          BREAK_TIME_US = 32'h0000_03E8;
  localparam int          BREAK_CYCLES  = (BREAK_TIME_US * CLK_KHZ + 999) / 1000;

  typedef enum logic [1:0] {
    HPSR_ROUTE_HANDLER = 2'b00,
    HPSR_ROUTE_PORT    = 2'b01,
    HPSR_ROUTE_CATCHUP = 2'b10
  } hpsr_route_t;

  typedef enum logic [1:0] {
    HPSR_OUT_IDLE  = 2'b00,
    HPSR_OUT_PKT   = 2'b01,
    HPSR_OUT_FETCH = 2'b10
  } hpsr_out_t;

endpackage : hpsr_pkg

// ### design/hpsr_router.sv
// Purpose: route host byte stream to command handler or one port
// Assumes: control strobes come from the command decoder, one cycle each
// Notes:   held bytes replayed from the stored escape string
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// - power-on routes host stream to handler
// - connect steers stream to chosen port
// - connected: bytes flow both ways
// - store escape string, end connection on it
// - escape compare exact, case sensitive
// - matching bytes held, not forwarded
// - mismatch sends held bytes, then new one unless it restarts the escape
// - no timeout releases held bytes
// - withheld bytes caught up before later data
// - send and broadcast payloads to ports
// - pass-through ports wrap data in packets
// - poll count, status, retrieve pending bytes
// - soft reset keeps baud rates
// - flush empties buffers; break on modules
// - GPIB linefeed and EOI translation
// - verbosity 127 copies host input to eavesdrop
// - unrouted port data sets pending flag
// - pass-through mask one bit per port
module hpsr_router #(
  parameter int PEND_DEPTH   = hpsr_pkg::PEND_WORDS,
  parameter int FIFO_DEPTH   = hpsr_pkg::FIFO_WORDS,
  parameter int BREAK_CYCLES = hpsr_pkg::BREAK_CYCLES
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        nrst_i,
  // host input stream
  input  wire logic        host_in_valid_i,
  input  wire logic [7:0]  host_in_data_i,
  input  wire logic        host_in_eoi_i,
  output logic             host_in_ready_o,
  // host output stream
  output logic             host_out_valid_o,
  output logic      [7:0]  host_out_data_o,
  output logic             host_out_eoi_o,
  input  wire logic        host_out_ready_i,
  // command handler side
  output logic             cmd_valid_o,
  output logic      [7:0]  cmd_data_o,
  input  wire logic        cmd_ready_i,
  input  wire logic        resp_valid_i,
  input  wire logic [7:0]  resp_data_i,
  output logic             resp_ready_o,
  // control from the command decoder
  input  wire logic        soft_reset_i,
  input  wire logic        connect_port_cmd_i,
  input  wire logic [3:0]  connect_port_cmd_port_i,
  input  wire logic [8*hpsr_pkg::ESC_MAX-1:0] esc_str_i,
  input  wire logic [3:0]  esc_len_i,
  input  wire logic        msg_valid_i,
  input  wire logic [7:0]  msg_data_i,
  input  wire logic [15:0] msg_port_mask_i,
  output logic             msg_ready_o,
  input  wire logic [15:0] passthrough_enable_mask_i,
  input  wire logic        pending_count_query_i,
  input  wire logic [3:0]  query_port_i,
  output logic      [$clog2(PEND_DEPTH):0] pending_count_o,
  input  wire logic        pending_data_status_rd_i,
  input  wire logic [15:0] pending_clear_mask_i,
  output logic      [15:0] data_pending_flags_o,
  input  wire logic        fetch_valid_i,
  input  wire logic [3:0]  fetch_port_i,
  input  wire logic [$clog2(PEND_DEPTH):0] fetch_count_i,
  output logic             fetch_ready_o,
  input  wire logic        flush_buffers_cmd_i,
  input  wire logic        module_break_cmd_i,
  input  wire logic        baud_wr_i,
  input  wire logic [3:0]  baud_port_i,
  input  wire logic [hpsr_pkg::BAUD_W-1:0] baud_val_i,
  output logic      [16*hpsr_pkg::BAUD_W-1:0] baud_rates_o,
  input  wire logic        host_is_gpib_i,
  input  wire logic        eoi_to_linefeed_opt_i,
  input  wire logic        linefeed_to_eoi_opt_i,
  input  wire logic [6:0]  verbosity_level_i,
  // port side
  output logic             tx_valid_o,
  output logic      [7:0]  tx_data_o,
  output logic      [15:0] tx_port_mask_o,
  input  wire logic        tx_ready_i,
  input  wire logic        rx_valid_i,
  input  wire logic [3:0]  rx_port_i,
  input  wire logic [7:0]  rx_data_i,
  output logic             rx_ready_o,
  output logic      [15:0] module_break_o,
  // eavesdrop copy
  output logic             eaves_valid_o,
  output logic      [7:0]  eaves_data_o
);
  localparam int PW = $clog2(PEND_DEPTH);
  localparam int NP = hpsr_pkg::NPORT;

  hpsr_pkg::hpsr_route_t route_reg;
  hpsr_pkg::hpsr_out_t   out_reg;
  logic [3:0]            connect_port_cmd_port_reg;
  logic [8*hpsr_pkg::ESC_MAX-1:0] esc_reg;
  logic [3:0]            esc_len_reg;
  logic [3:0]            match_len_reg;
  logic [3:0]            replay_idx_reg;
  logic [7:0]            mism_reg;
  logic                  in_lf_pend_reg;
  logic                  in_valid;
  logic [7:0]            in_byte;
  logic                  in_can_take;
  logic                  in_take;
  logic [7:0]            esc_cur;
  logic [7:0]            esc_first;
  logic                  esc_hit;
  logic                  tx_free;
  logic                  cmd_free;
  logic                  route_emit;
  logic [7:0]            emit_byte;
  logic [7:0]            pend_mem [NP][PEND_DEPTH];
  logic [PW:0]           pend_cnt_reg [NP];
  logic [PW-1:0]         pend_wr_reg [NP];
  logic [PW-1:0]         pend_rd_reg [NP];
  logic                  pend_store;
  logic                  pend_pop;
  logic [3:0]            pkt_port_reg;
  logic [7:0]            pkt_data_reg;
  logic [1:0]            pkt_idx_reg;
  logic [3:0]            fetch_port_reg;
  logic [PW:0]           fetch_left_reg;
  logic [PW:0]           fetch_avail;
  logic                  push_valid;
  logic [7:0]            push_data;
  logic                  fifo_in_ready;
  logic [8:0]            fifo_out;
  logic                  rx_connect_port_cmd;
  logic                  rx_pt;
  logic [31:0]           break_cnt_reg;

  // host input: optional EOI to linefeed insertion
  assign in_valid  = host_in_valid_i || in_lf_pend_reg;
  assign in_byte   = in_lf_pend_reg ? hpsr_pkg::CHAR_LF : host_in_data_i;
  assign tx_free   = !tx_valid_o || tx_ready_i;
  assign cmd_free  = !cmd_valid_o || cmd_ready_i;
  assign in_can_take = (route_reg == hpsr_pkg::HPSR_ROUTE_HANDLER) ? cmd_free :
                       (route_reg == hpsr_pkg::HPSR_ROUTE_PORT) ? tx_free : 1'b0;
  assign in_take   = in_valid && in_can_take;
  assign host_in_ready_o = in_can_take && !in_lf_pend_reg;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      in_lf_pend_reg <= 1'b0;
    end else if (in_take && in_lf_pend_reg) begin
      in_lf_pend_reg <= 1'b0;
    end else if (in_take && host_in_eoi_i && host_is_gpib_i && eoi_to_linefeed_opt_i
                 && host_in_data_i != hpsr_pkg::CHAR_LF) begin
      in_lf_pend_reg <= 1'b1;
    end
  end

  // escape matching compares raw bytes, so case is significant
  assign esc_cur   = esc_reg[{match_len_reg[2:0], 3'b000} +: 8];
  assign esc_first = esc_reg[7:0];
  assign esc_hit   = (esc_len_reg != 4'h0) && (in_byte == esc_cur);

  always_comb begin
    route_emit = 1'b0;
    emit_byte  = in_byte;
    case (route_reg)
      hpsr_pkg::HPSR_ROUTE_PORT: begin
        route_emit = in_take && !esc_hit && (match_len_reg == 4'h0);
      end
      hpsr_pkg::HPSR_ROUTE_CATCHUP: begin
        if (replay_idx_reg < match_len_reg) begin
          route_emit = tx_free;
          emit_byte  = esc_reg[{replay_idx_reg[2:0], 3'b000} +: 8];
        end else begin
          route_emit = tx_free && (mism_reg != esc_first);
          emit_byte  = mism_reg;
        end
      end
      default: begin
        route_emit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      route_reg      <= hpsr_pkg::HPSR_ROUTE_HANDLER;
      connect_port_cmd_port_reg  <= 4'h0;
      esc_reg        <= '0;
      esc_len_reg    <= 4'h0;
      match_len_reg  <= 4'h0;
      replay_idx_reg <= 4'h0;
      mism_reg       <= 8'h00;
    end else if (soft_reset_i) begin
      route_reg     <= hpsr_pkg::HPSR_ROUTE_HANDLER;
      match_len_reg <= 4'h0;
    end else if (connect_port_cmd_i) begin
      route_reg     <= hpsr_pkg::HPSR_ROUTE_PORT;
      connect_port_cmd_port_reg <= connect_port_cmd_port_i;
      esc_reg       <= esc_str_i;
      esc_len_reg   <= (esc_len_i > 4'h8) ? 4'h8 : esc_len_i;
      match_len_reg <= 4'h0;
    end else begin
      case (route_reg)
        hpsr_pkg::HPSR_ROUTE_PORT: begin
          // no timer here: held bytes wait only on host data
          if (in_take && esc_hit) begin
            if (match_len_reg + 4'h1 == esc_len_reg) begin
              route_reg     <= hpsr_pkg::HPSR_ROUTE_HANDLER;
              match_len_reg <= 4'h0;
            end else begin
              match_len_reg <= match_len_reg + 4'h1;
            end
          end else if (in_take && match_len_reg != 4'h0) begin
            mism_reg       <= in_byte;
            replay_idx_reg <= 4'h0;
            route_reg      <= hpsr_pkg::HPSR_ROUTE_CATCHUP;
          end
        end
        hpsr_pkg::HPSR_ROUTE_CATCHUP: begin
          if (tx_free) begin
            if (replay_idx_reg < match_len_reg) begin
              replay_idx_reg <= replay_idx_reg + 4'h1;
            end else begin
              route_reg     <= hpsr_pkg::HPSR_ROUTE_PORT;
              match_len_reg <= (mism_reg == esc_first) ? 4'h1 : 4'h0;
            end
          end
        end
        default: begin
          route_reg <= hpsr_pkg::HPSR_ROUTE_HANDLER;
        end
      endcase
    end
  end

  // handler byte stage
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cmd_valid_o <= 1'b0;
      cmd_data_o  <= 8'h00;
    end else if (in_take && route_reg == hpsr_pkg::HPSR_ROUTE_HANDLER) begin
      cmd_valid_o <= 1'b1;
      cmd_data_o  <= in_byte;
    end else if (cmd_ready_i) begin
      cmd_valid_o <= 1'b0;
    end
  end

  // port byte stage; messages only while not connected
  assign msg_ready_o = (route_reg == hpsr_pkg::HPSR_ROUTE_HANDLER) && tx_free;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tx_valid_o     <= 1'b0;
      tx_data_o      <= 8'h00;
      tx_port_mask_o <= 16'h0000;
    end else if (route_emit) begin
      tx_valid_o     <= 1'b1;
      tx_data_o      <= emit_byte;
      tx_port_mask_o <= 16'h0001 << connect_port_cmd_port_reg;
    end else if (msg_valid_i && msg_ready_o) begin
      tx_valid_o     <= 1'b1;
      tx_data_o      <= msg_data_i;
      tx_port_mask_o <= msg_port_mask_i;
    end else if (tx_ready_i) begin
      tx_valid_o <= 1'b0;
    end
  end

  // host output feeder
  assign rx_connect_port_cmd     = (route_reg != hpsr_pkg::HPSR_ROUTE_HANDLER) && (rx_port_i == connect_port_cmd_port_reg);
  assign rx_pt       = passthrough_enable_mask_i[rx_port_i];
  assign fetch_avail = (fetch_count_i < pend_cnt_reg[fetch_port_i]) ?
                       fetch_count_i : pend_cnt_reg[fetch_port_i];

  always_comb begin
    push_valid    = 1'b0;
    push_data     = rx_data_i;
    rx_ready_o    = 1'b0;
    resp_ready_o  = 1'b0;
    fetch_ready_o = 1'b0;
    pend_store    = 1'b0;
    pend_pop      = 1'b0;
    case (out_reg)
      hpsr_pkg::HPSR_OUT_IDLE: begin
        fetch_ready_o = 1'b1;
        if (fetch_valid_i) begin
          push_valid = 1'b0;
        end else if (rx_valid_i && rx_connect_port_cmd) begin
          push_valid = 1'b1;
          rx_ready_o = fifo_in_ready;
        end else if (rx_valid_i && rx_pt) begin
          rx_ready_o = 1'b1;
        end else if (rx_valid_i) begin
          rx_ready_o = pend_cnt_reg[rx_port_i] != (PW+1)'(PEND_DEPTH);
          pend_store = rx_ready_o;
        end else if (resp_valid_i) begin
          push_valid   = 1'b1;
          push_data    = resp_data_i;
          resp_ready_o = fifo_in_ready;
        end
      end
      hpsr_pkg::HPSR_OUT_PKT: begin
        push_valid = 1'b1;
        case (pkt_idx_reg)
          2'd0:    push_data = hpsr_pkg::PKT_MARK;
          2'd1:    push_data = {4'h0, pkt_port_reg};
          2'd2:    push_data = hpsr_pkg::PKT_COUNT;
          default: push_data = pkt_data_reg;
        endcase
      end
      hpsr_pkg::HPSR_OUT_FETCH: begin
        push_valid = 1'b1;
        push_data  = pend_mem[fetch_port_reg][pend_rd_reg[fetch_port_reg]];
        pend_pop   = fifo_in_ready;
      end
      default: begin
        push_valid = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      out_reg        <= hpsr_pkg::HPSR_OUT_IDLE;
      pkt_port_reg   <= 4'h0;
      pkt_data_reg   <= 8'h00;
      pkt_idx_reg    <= 2'd0;
      fetch_port_reg <= 4'h0;
      fetch_left_reg <= '0;
    end else if (flush_buffers_cmd_i || soft_reset_i) begin
      out_reg <= hpsr_pkg::HPSR_OUT_IDLE;
    end else begin
      case (out_reg)
        hpsr_pkg::HPSR_OUT_IDLE: begin
          if (fetch_valid_i) begin
            fetch_port_reg <= fetch_port_i;
            fetch_left_reg <= fetch_avail;
            if (fetch_avail != '0) out_reg <= hpsr_pkg::HPSR_OUT_FETCH;
          end else if (rx_valid_i && !rx_connect_port_cmd && rx_pt) begin
            pkt_port_reg <= rx_port_i;
            pkt_data_reg <= rx_data_i;
            pkt_idx_reg  <= 2'd0;
            out_reg      <= hpsr_pkg::HPSR_OUT_PKT;
          end
        end
        hpsr_pkg::HPSR_OUT_PKT: begin
          if (fifo_in_ready) begin
            pkt_idx_reg <= pkt_idx_reg + 2'd1;
            if (pkt_idx_reg == 2'd3) out_reg <= hpsr_pkg::HPSR_OUT_IDLE;
          end
        end
        hpsr_pkg::HPSR_OUT_FETCH: begin
          if (fifo_in_ready) begin
            fetch_left_reg <= fetch_left_reg - 1'b1;
            if (fetch_left_reg == (PW+1)'(1)) out_reg <= hpsr_pkg::HPSR_OUT_IDLE;
          end
        end
        default: begin
          out_reg <= hpsr_pkg::HPSR_OUT_IDLE;
        end
      endcase
    end
  end

  // pending byte store, memory without reset
  always_ff @(posedge clk_i) begin
    if (pend_store) begin
      pend_mem[rx_port_i][pend_wr_reg[rx_port_i]] <= rx_data_i;
    end
  end

  genvar g;
  generate
    for (g = 0; g < NP; g++) begin : g_port
      logic set_flag;
      assign set_flag = pend_store && (rx_port_i == 4'(g));

      always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
          pend_cnt_reg[g] <= '0;
          pend_wr_reg[g]  <= '0;
          pend_rd_reg[g]  <= '0;
        end else if (flush_buffers_cmd_i) begin
          pend_cnt_reg[g] <= '0;
          pend_wr_reg[g]  <= '0;
          pend_rd_reg[g]  <= '0;
        end else if (set_flag) begin
          pend_cnt_reg[g] <= pend_cnt_reg[g] + 1'b1;
          pend_wr_reg[g]  <= pend_wr_reg[g] + 1'b1;
        end else if (pend_pop && fetch_port_reg == 4'(g)) begin
          pend_cnt_reg[g] <= pend_cnt_reg[g] - 1'b1;
          pend_rd_reg[g]  <= pend_rd_reg[g] + 1'b1;
        end
      end

      // a new byte wins over a read-clear in the same cycle
      always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
          data_pending_flags_o[g] <= 1'b0;
        end else if (set_flag && g != 0) begin
          data_pending_flags_o[g] <= 1'b1;
        end else if (soft_reset_i ||
                     (pending_data_status_rd_i && pending_clear_mask_i[g])) begin
          data_pending_flags_o[g] <= 1'b0;
        end
      end

      // baud rates survive the soft reset, only power-on resets them
      always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
          baud_rates_o[g*hpsr_pkg::BAUD_W +: hpsr_pkg::BAUD_W] <= hpsr_pkg::BAUD_DEFAULT;
        end else if (baud_wr_i && baud_port_i == 4'(g)) begin
          baud_rates_o[g*hpsr_pkg::BAUD_W +: hpsr_pkg::BAUD_W] <= baud_val_i;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pending_count_o <= '0;
    end else if (pending_count_query_i) begin
      pending_count_o <= pend_cnt_reg[query_port_i];
    end
  end

  // serial break on every module port
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      break_cnt_reg  <= 32'h0000_0000;
      module_break_o <= 16'h0000;
    end else if (module_break_cmd_i) begin
      break_cnt_reg  <= 32'(BREAK_CYCLES);
      module_break_o <= hpsr_pkg::MODULE_PORT_MASK;
    end else if (break_cnt_reg > 32'h0000_0001) begin
      break_cnt_reg <= break_cnt_reg - 32'h0000_0001;
    end else begin
      break_cnt_reg  <= 32'h0000_0000;
      module_break_o <= 16'h0000;
    end
  end

  // eavesdrop copy has no back-pressure; listener must keep up
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      eaves_valid_o <= 1'b0;
      eaves_data_o  <= 8'h00;
    end else begin
      eaves_valid_o <= in_take && (verbosity_level_i == hpsr_pkg::VERBOSITY_LEVEL_DEBUG);
      eaves_data_o  <= in_byte;
    end
  end

  hpsr_fifo #(
    .WIDTH (9),
    .DEPTH (FIFO_DEPTH)
  ) u_host_out_fifo (
    .clk_i       (clk_i),
    .nrst_i      (nrst_i),
    .flush_i     (flush_buffers_cmd_i),
    .in_valid_i  (push_valid),
    .in_data_i   ({host_is_gpib_i && linefeed_to_eoi_opt_i &&
                   push_data == hpsr_pkg::CHAR_LF, push_data}),
    .in_ready_o  (fifo_in_ready),
    .out_valid_o (host_out_valid_o),
    .out_data_o  (fifo_out),
    .out_ready_i (host_out_ready_i)
  );

  assign host_out_data_o = fifo_out[7:0];
  assign host_out_eoi_o  = fifo_out[8];

endmodule : hpsr_router
`default_nettype wire

// ### test/hpsr_asserts.sv
// Purpose: port checks of the stream router
// Assumes: break shortened to 8 cycles
// Notes: sees router ports only
`timescale 1ns/100ps
`default_nettype none
module hpsr_asserts (
  input wire logic clk_i, nrst_i, host_in_valid_i, host_in_ready_o, cmd_valid_o, tx_valid_o,
  input wire logic connect_port_cmd_i, msg_valid_i, msg_ready_o, tx_ready_i, soft_reset_i,
  input wire logic baud_wr_i, module_break_cmd_i, eaves_valid_o, host_out_valid_o,
  input wire logic host_out_eoi_o, flush_buffers_cmd_i,
  input wire logic [7:0] host_in_data_i, cmd_data_o, msg_data_i, tx_data_o, eaves_data_o,
  input wire logic [7:0] host_out_data_o,
  input wire logic [15:0] msg_port_mask_i, tx_port_mask_o, module_break_o,
  input wire logic [6:0] verbosity_level_i,
  input wire logic [287:0] baud_rates_o
);
  logic connect_port_cmd_seen_reg;
  wire take = host_in_valid_i && host_in_ready_o;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  // weak after the first connect, but never a false alarm
  always_ff @(posedge clk_i or negedge nrst_i)
    if (!nrst_i) connect_port_cmd_seen_reg <= 1'b0;
    else if (connect_port_cmd_i) connect_port_cmd_seen_reg <= 1'b1;
  power_on_route_a: assert property (take && !connect_port_cmd_seen_reg |=> cmd_valid_o &&
    cmd_data_o == $past(host_in_data_i)) else $error("byte missed handler");
  eaves_copy_a: assert property (take && verbosity_level_i == 7'h7F |=> eaves_valid_o &&
    eaves_data_o == $past(host_in_data_i)) else $error("no eavesdrop copy");
  msg_send_a: assert property (msg_valid_i && msg_ready_o |=> tx_valid_o &&
    tx_data_o == $past(msg_data_i) && tx_port_mask_o == $past(msg_port_mask_i))
    else $error("message not sent");
  tx_hold_a: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o))
    else $error("port byte dropped");
  baud_keep_a: assert property (soft_reset_i && !baud_wr_i |=> $stable(baud_rates_o))
    else $error("baud changed by reset");
  break_len_a: assert property (module_break_cmd_i |=> module_break_o == 16'h03FE [*8]
    ##1 module_break_o == 16'h0000) else $error("bad break length");
  flush_empty_a: assert property (flush_buffers_cmd_i |=> !host_out_valid_o)
    else $error("queue not flushed");
  eoi_lf_a: assert property (host_out_valid_o && host_out_eoi_o |-> host_out_data_o == 8'h0A)
    else $error("eoi on non linefeed");
endmodule : hpsr_asserts
bind hpsr_router hpsr_asserts hpsr_asserts_inst (.*);
`default_nettype wire

// ### test/hpsr_port_model.sv
// Purpose: instrument ports behind the router
// Assumes: slow ports take a byte every other cycle
// Notes: bytes logged for the bench
`timescale 1ns/100ps
`default_nettype none
module hpsr_port_model (
  input  wire logic       clk_i,
  input  wire logic       nrst_i,
  input  wire logic       slow_i,
  input  wire logic       tx_valid_i,
  input  wire logic [7:0] tx_data_i,
  output logic            tx_ready_o
);
  logic [7:0] log_q[$];
  logic       tick_reg;
  always_ff @(posedge clk_i or negedge nrst_i)
    if (!nrst_i) tick_reg <= 1'b0;
    else tick_reg <= !tick_reg;
  assign tx_ready_o = !slow_i || tick_reg;
  always @(posedge clk_i) if (tx_valid_i && tx_ready_o) log_q.push_back(tx_data_i);
endmodule : hpsr_port_model
`default_nettype wire

// ### test/testbench.sv
// Purpose: self-checking bench of the stream router
// Assumes: break shortened to 8 cycles
// Notes: monitors gather host and handler bytes
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic clk_i, nrst_i, slow, host_in_ready_o, host_out_valid_o, host_out_eoi_o, cmd_valid_o;
  logic resp_ready_o, msg_ready_o, fetch_ready_o, tx_valid_o, tx_ready_i, rx_ready_o, eaves_valid_o;
  logic [7:0] host_out_data_o, cmd_data_o, tx_data_o, eaves_data_o, hq[$], cq[$];
  logic [15:0] data_pending_flags_o, tx_port_mask_o, module_break_o;
  logic [2:0] pending_count_o, fetch_count_i = '0;
  logic [287:0] baud_rates_o;
  logic host_in_valid_i = 0, host_in_eoi_i = 0, resp_valid_i = 0, soft_reset_i = 0, rx_valid_i = 0;
  logic connect_port_cmd_i = 0, msg_valid_i = 0, pending_count_query_i = 0, fetch_valid_i = 0;
  logic pending_data_status_rd_i = 0, flush_buffers_cmd_i = 0, module_break_cmd_i = 0;
  logic baud_wr_i = 0, eoi_to_linefeed_opt_i = 0, cmd_ready_i = 1, host_out_ready_i = 1;
  logic host_is_gpib_i = 1, linefeed_to_eoi_opt_i = 1;
  logic [7:0] host_in_data_i = '0, resp_data_i = '0, msg_data_i = '0, rx_data_i = '0;
  logic [3:0] connect_port_cmd_port_i = '0, esc_len_i = '0, query_port_i = '0, fetch_port_i = '0;
  logic [3:0] baud_port_i = '0, rx_port_i = '0;
  logic [15:0] msg_port_mask_i = '0, passthrough_enable_mask_i = '0, pending_clear_mask_i = '0;
  logic [63:0] esc_str_i = '0;
  logic [17:0] baud_val_i = '0;
  logic [6:0] verbosity_level_i = 7'h7F;
  int fails = 0, tests_run = 0;
  hpsr_router #(.BREAK_CYCLES(8)) hpsr_router_inst (.*);
  hpsr_port_model hpsr_port_model_inst (.clk_i, .nrst_i, .slow_i(slow),
    .tx_valid_i(tx_valid_o), .tx_data_i(tx_data_o), .tx_ready_o(tx_ready_i));
  initial begin
    clk_i = 0;
    forever #25 clk_i = !clk_i;
  end
  always @(posedge clk_i) begin
    if (host_out_valid_o && host_out_ready_i) hq.push_back(host_out_data_o);
    if (cmd_valid_o && cmd_ready_i) cq.push_back(cmd_data_o);
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : tick
  task automatic chk(input logic [31:0] e, input logic [31:0] a);
    tests_run++;
    if (e !== a) begin
      fails++;
      $display("unexpected at %0t: exp %h got %h", $time, e, a);
    end
  endtask : chk
  // request held from just after an edge until ready is seen
  task automatic hs(ref logic rdy);
    int n;
    // ready may hang on the request just driven: let it settle first
    #1;
    for (n = 0; n < 200 && rdy !== 1'b1; n++) tick(1);
    if (n == 200) begin
      fails++;
      end_of_test();
    end
    tick(1);
  endtask : hs
  task automatic pulse(ref logic p);
    p = 1;
    tick(1);
    p = 0;
  endtask : pulse
  task automatic send(input string s);
    host_in_valid_i = 1;
    foreach (s[i]) begin
      host_in_data_i = s[i];
      hs(host_in_ready_o);
    end
    host_in_valid_i = 0;
  endtask : send
  task automatic rx(input logic [3:0] p, input logic [7:0] d);
    {rx_valid_i, rx_port_i, rx_data_i} = {1'b1, p, d};
    hs(rx_ready_o);
    rx_valid_i = 0;
  endtask : rx
  task automatic escape_case;
    string exp_s = "ABCDEFGdefD";
    send("I");
    tick(3);
    chk("I", cq[0]);
    {slow, connect_port_cmd_port_i, esc_len_i} = {1'b1, 4'h3, 4'h4};
    esc_str_i = 64'h0000_0000_5146_4544;
    pulse(connect_port_cmd_i);
    send("ABCDEF");
    tick(50);
    chk(3, hpsr_port_model_inst.log_q.size());
    rx(4'h3, 8'h33);
    send("Gdef");
    send("DDEFQ");
    send("Z");
    tick(20);
    chk(8'h33, hq[0]);
    chk(11, hpsr_port_model_inst.log_q.size());
    foreach (exp_s[i]) chk(exp_s[i], hpsr_port_model_inst.log_q[i]);
    chk("Z", cq[$]);
  endtask : escape_case
  task automatic poll_case;
    rx(4'h5, 8'h55);
    tick(2);
    chk(16'h0020, data_pending_flags_o);
    query_port_i = 4'h5;
    pulse(pending_count_query_i);
    chk(1, pending_count_o);
    {fetch_valid_i, fetch_port_i, fetch_count_i} = {1'b1, 4'h5, 3'h2};
    hs(fetch_ready_o);
    fetch_valid_i = 0;
    tick(5);
    chk(8'h55, hq[$]);
    passthrough_enable_mask_i = 16'h0FFE;
    rx(4'h2, 8'h0A);
    tick(10);
    chk(32'h2302_010A, {hq[$-3], hq[$-2], hq[$-1], hq[$]});
  endtask : poll_case
  task automatic misc_case;
    chk(18'h0_2580, baud_rates_o[36 +: 18]);
    {baud_port_i, baud_val_i} = {4'h1, 18'h0_4B00};
    pulse(baud_wr_i);
    pulse(soft_reset_i);
    chk(18'h0_4B00, baud_rates_o[18 +: 18]);
    {msg_valid_i, msg_data_i, msg_port_mask_i} = {1'b1, 8'h4D, 16'h0006};
    hs(msg_ready_o);
    msg_valid_i = 0;
    tick(5);
    chk(8'h4D, hpsr_port_model_inst.log_q[$]);
    pulse(module_break_cmd_i);
    tick(2);
    chk(16'h03FE, module_break_o);
    // stalled host side: queue fills until the port is refused
    host_out_ready_i = 0;
    {rx_valid_i, rx_port_i} = {1'b1, 4'h2};
    tick(30);
    chk(0, rx_ready_o);
    rx_valid_i = 0;
    pulse(flush_buffers_cmd_i);
    chk(0, host_out_valid_o);
    host_out_ready_i = 1;
  endtask : misc_case
  task automatic end_of_test;
    $display("comparisons %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_of_test
  initial begin
    {slow, nrst_i} = 2'b00;
    repeat (8) @(posedge clk_i);
    #1 nrst_i = 1;
    tick(1);
    escape_case();
    poll_case();
    misc_case();
    end_of_test();
  end
endmodule : testbench
`default_nettype wire
